// ==== qpc_classifier.sv ====
// QoS priority classifier with APB registers and egress scheduler
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Ten per-port levels, four values each
// - Eight-entry class-of-service level table
// - Sixty-four-entry type-of-service level table
// - Type-of-service table resets to lowest
// - Type-of-service-only IP frames use table entry
// - Weighted scheduling in 8:4:2:1 ratio
// - Strict mode serves highest non-empty queue
// - Five priority selections plus disable
// - First-source selections fall back otherwise
module qpc_classifier
  import qpc_pkg::*;
#(
  parameter int unsigned NPORTS = NUM_PORTS
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic              pslverr,
  output logic [31:0]       prdata,
  input  wire logic         in_valid,
  input  wire qpc_frame_t   in_frame,
  output logic              out_valid,
  output logic [3:0]        out_port,
  output logic [1:0]        out_queue,
  input  wire logic [3:0]   q_nonempty,
  input  wire logic         grant_ready,
  output logic              grant_valid,
  output logic [1:0]        grant_q
);

  if (NPORTS != 10) begin : g_bad_nports
    $error("qpc_classifier serves exactly ten ports");
  end

  qpc_cfg_t          cfg_q;
  logic [2*NPORTS-1:0] port_lvl_q;
  logic [15:0]       cos_map_q;
  logic [1:0]        tos_map_q [TOS_ENTRIES];
  logic [15:0]       frame_cnt_q;
  logic              wr_en;
  logic              rd_en;
  logic              addr_ok;
  logic              tos_hit;
  logic [1:0]        tos_word;
  logic [31:0]       tos_rd;
  logic [1:0]        lvl_port;
  logic [1:0]        lvl_cos;
  logic [1:0]        lvl_tos;
  logic              cos_avail;
  logic              tos_avail;
  logic [1:0]        lvl_d;
  logic              frame_ok;

  // Single-cycle access phase, no wait states
  assign pready  = 1'b1;
  assign wr_en   = ce && psel && penable && pwrite && addr_ok;
  assign rd_en   = psel && penable && !pwrite;
  assign tos_hit = (paddr[11:4] == OFS_TOS_BASE[11:4]);
  assign tos_word = paddr[3:2];

  always_comb begin
    addr_ok = 1'b0;
    case (paddr)
      OFS_CTRL, OFS_PORT_LVL, OFS_COS_MAP, OFS_STATUS, OFS_COUNT: addr_ok = 1'b1;
      default: addr_ok = tos_hit && (paddr[1:0] == 2'h0);
    endcase
  end

  // Unmapped addresses answer with an error and read as zero
  assign pslverr = psel && penable && !addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q.strict <= RST_CTRL[CTRL_STRICT_BIT];
      cfg_q.sel    <= RST_CTRL[CTRL_SEL_LSB +: 3];
    end else if (wr_en && paddr == OFS_CTRL) begin
      cfg_q.strict <= pwdata[CTRL_STRICT_BIT];
      // Unused selection codes fall back to disable
      cfg_q.sel    <= (pwdata[CTRL_SEL_LSB +: 3] > SEL_TOS_FIRST) ?
                      SEL_DISABLE : pwdata[CTRL_SEL_LSB +: 3];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_lvl_q <= RST_PORT_LVL;
    end else if (wr_en && paddr == OFS_PORT_LVL) begin
      port_lvl_q <= pwdata[2*NPORTS-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cos_map_q <= RST_COS_MAP;
    end else if (wr_en && paddr == OFS_COS_MAP) begin
      cos_map_q <= pwdata[15:0];
    end
  end

  // Sixteen two-bit entries per word, four words
  generate
    for (genvar e = 0; e < TOS_ENTRIES; e++) begin : g_tos
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tos_map_q[e] <= LVL_LOWEST;
        end else if (wr_en && tos_hit && tos_word == 2'(e / 16)) begin
          tos_map_q[e] <= pwdata[2*(e%16) +: 2];
        end
      end
    end
  endgenerate

  always_comb begin
    tos_rd = 32'h0000_0000;
    for (int k = 0; k < 16; k++) begin
      tos_rd[2*k +: 2] = tos_map_q[{tos_word, 4'(k)}];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !penable && !pwrite) begin
      // Read data is latched in setup so it is a flip-flop at access
      prdata <= 32'h0000_0000;
      case (paddr)
        OFS_CTRL:     prdata <= {25'h0, cfg_q.sel, 3'h0, cfg_q.strict};
        OFS_PORT_LVL: prdata <= {12'h0, port_lvl_q};
        OFS_COS_MAP:  prdata <= {16'h0, cos_map_q};
        OFS_STATUS:   prdata <= {26'h0, grant_valid, grant_q, q_nonempty[0], out_queue};
        OFS_COUNT:    prdata <= {16'h0, frame_cnt_q};
        default:      prdata <= addr_ok ? tos_rd : 32'h0000_0000;
      endcase
    end
  end

  // Lookups for one arriving frame
  assign lvl_port  = port_lvl_q[2*in_frame.port +: 2];
  assign lvl_cos   = cos_map_q[2*in_frame.cos +: 2];
  assign lvl_tos   = tos_map_q[in_frame.tos];
  assign cos_avail = in_frame.has_cos;
  assign tos_avail = in_frame.is_ip;
  // Only frames from existing ports are classified; others would index past the table
  assign frame_ok  = ce && in_valid && (in_frame.port < 4'(NPORTS));

  always_comb begin
    lvl_d = LVL_LOWEST;
    case (cfg_q.sel)
      SEL_PORT:     lvl_d = lvl_port;
      SEL_COS_ONLY: lvl_d = cos_avail ? lvl_cos : LVL_LOWEST;
      SEL_TOS_ONLY: lvl_d = tos_avail ? lvl_tos : LVL_LOWEST;
      SEL_COS_FIRST: begin
        // Fallback order: other header source, then port level
        if (cos_avail) lvl_d = lvl_cos;
        else if (tos_avail) lvl_d = lvl_tos;
        else lvl_d = lvl_port;
      end
      SEL_TOS_FIRST: begin
        if (tos_avail) lvl_d = lvl_tos;
        else if (cos_avail) lvl_d = lvl_cos;
        else lvl_d = lvl_port;
      end
      default: lvl_d = LVL_LOWEST;
    endcase
  end

  // Frames from a non-existent port are dropped, not classified
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_port  <= 4'h0;
      out_queue <= LVL_LOWEST;
    end else if (ce) begin
      out_valid <= frame_ok;
      if (frame_ok) begin
        out_port  <= in_frame.port;
        out_queue <= lvl_d;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_cnt_q <= 16'h0000;
    end else if (ce && out_valid) begin
      frame_cnt_q <= frame_cnt_q + 16'h0001;
    end
  end

  qpc_sched #(
    .NQ (NUM_QUEUES)
  ) u_sched (
    .pclk        (pclk),
    .presetn     (presetn),
    .ce          (ce),
    .strict      (cfg_q.strict),
    .q_nonempty  (q_nonempty),
    .grant_ready (grant_ready),
    .grant_valid (grant_valid),
    .grant_q     (grant_q)
  );

  AST_TOS_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    (frame_ok && in_frame.is_ip && cfg_q.sel == SEL_TOS_ONLY)
    |=> out_valid && out_queue == $past(tos_map_q[in_frame.tos]))
    else $error("type-of-service-only frame got wrong queue");

  AST_PORT_BASED: assert property (@(posedge pclk) disable iff (!presetn)
    (frame_ok && cfg_q.sel == SEL_PORT) |=> out_queue == $past(lvl_port))
    else $error("port-based frame got wrong queue");

  AST_COS_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
    (frame_ok && cfg_q.sel == SEL_COS_FIRST && !in_frame.has_cos && !in_frame.is_ip)
    |=> out_queue == $past(lvl_port))
    else $error("class-of-service-first fallback wrong");

  AST_DISABLE: assert property (@(posedge pclk) disable iff (!presetn)
    (frame_ok && cfg_q.sel == SEL_DISABLE) |=> out_queue == LVL_LOWEST)
    else $error("disabled selection did not give lowest");

  AST_SEL_LEGAL: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_q.sel <= SEL_TOS_FIRST)
    else $error("illegal selection stored");

  AST_COS_MAP: assert property (@(posedge pclk) disable iff (!presetn)
    (frame_ok && in_frame.has_cos && cfg_q.sel == SEL_COS_ONLY)
    |=> out_queue == $past(cos_map_q[2*in_frame.cos +: 2]))
    else $error("class-of-service mapping wrong");

  AST_TOS_RESET: assert property (@(posedge pclk)
    $rose(presetn) |-> tos_map_q[0] == LVL_LOWEST && tos_map_q[63] == LVL_LOWEST)
    else $error("type-of-service table not lowest after reset");

  AST_TOS_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == OFS_TOS_BASE + 12'h00c) |=> tos_map_q[63] == $past(pwdata[31:30]))
    else $error("type-of-service entry 63 not written");

  AST_TOS_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
    (frame_ok && in_frame.is_ip && cfg_q.sel == SEL_TOS_FIRST)
    |=> out_queue == $past(tos_map_q[in_frame.tos]))
    else $error("type-of-service-first frame got wrong queue");

  AST_TOS_FIRST_COS: assert property (@(posedge pclk) disable iff (!presetn)
    (frame_ok && !in_frame.is_ip && in_frame.has_cos && cfg_q.sel == SEL_TOS_FIRST)
    |=> out_queue == $past(cos_map_q[2*in_frame.cos +: 2]))
    else $error("type-of-service-first fallback to class of service wrong");

  AST_COS_FIRST_TOS: assert property (@(posedge pclk) disable iff (!presetn)
    (frame_ok && !in_frame.has_cos && in_frame.is_ip && cfg_q.sel == SEL_COS_FIRST)
    |=> out_queue == $past(tos_map_q[in_frame.tos]))
    else $error("class-of-service-first fallback to type of service wrong");

  AST_ONLY_ABSENT: assert property (@(posedge pclk) disable iff (!presetn)
    (frame_ok && ((cfg_q.sel == SEL_COS_ONLY && !in_frame.has_cos) ||
                  (cfg_q.sel == SEL_TOS_ONLY && !in_frame.is_ip)))
    |=> out_queue == LVL_LOWEST)
    else $error("single-source selection without its field not lowest");

  AST_DROP_PORT: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && in_valid && in_frame.port >= 4'(NPORTS)) |=> !out_valid && $stable(out_queue))
    else $error("frame from a missing port was classified");

  AST_FREEZE: assert property (@(posedge pclk) disable iff (!presetn)
    !ce |=> $stable(out_valid) && $stable(frame_cnt_q) && $stable(port_lvl_q) &&
            $stable(cfg_q) && $stable(prdata))
    else $error("state changed while the clock enable was low");

  AST_PORT_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == OFS_PORT_LVL) |=> port_lvl_q == $past(pwdata[2*NPORTS-1:0]))
    else $error("port level write not stored");

  AST_COS_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == OFS_COS_MAP) |=> cos_map_q == $past(pwdata[15:0]))
    else $error("class-of-service table write not stored");

  AST_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && out_valid) |=> frame_cnt_q == $past(frame_cnt_q) + 16'h0001)
    else $error("classified frame not counted");

  AST_CTRL_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == OFS_CTRL && pwdata[CTRL_SEL_LSB +: 3] <= SEL_TOS_FIRST)
    |=> cfg_q.sel == $past(pwdata[CTRL_SEL_LSB +: 3]))
    else $error("legal selection not stored");

  AST_SEL_FALLBACK: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == OFS_CTRL && pwdata[CTRL_SEL_LSB +: 3] > SEL_TOS_FIRST)
    |=> cfg_q.sel == SEL_DISABLE)
    else $error("unused selection code not turned into disable");

  AST_UNMAPPED_READ: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && !addr_ok && $past(ce)) |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped read did not answer with an error and zero");

endmodule
`default_nettype wire

// ==== qpc_pkg.sv ====
// Package for the QoS priority classifier: constants, types and register map
package qpc_pkg;

  localparam int unsigned NUM_PORTS   = 10;
  localparam int unsigned NUM_QUEUES  = 4;
  localparam int unsigned COS_ENTRIES = 8;
  localparam int unsigned TOS_ENTRIES = 64;

  // Priority levels as queue indices
  localparam logic [1:0] LVL_LOWEST = 2'h0;
  localparam logic [1:0] LVL_LOW    = 2'h1;
  localparam logic [1:0] LVL_MIDDLE = 2'h2;
  localparam logic [1:0] LVL_HIGH   = 2'h3;

  // Priority-type selection codes
  localparam logic [2:0] SEL_DISABLE   = 3'h0;
  localparam logic [2:0] SEL_PORT      = 3'h1;
  localparam logic [2:0] SEL_COS_ONLY  = 3'h2;
  localparam logic [2:0] SEL_TOS_ONLY  = 3'h3;
  localparam logic [2:0] SEL_COS_FIRST = 3'h4;
  localparam logic [2:0] SEL_TOS_FIRST = 3'h5;

  // Weights of the weighted scheduler, lowest queue first
  localparam logic [3:0] WGT_Q0 = 4'h1;
  localparam logic [3:0] WGT_Q1 = 4'h2;
  localparam logic [3:0] WGT_Q2 = 4'h4;
  localparam logic [3:0] WGT_Q3 = 4'h8;

  // Register byte offsets
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_PORT_LVL = 12'h004;
  localparam logic [11:0] OFS_COS_MAP  = 12'h008;
  localparam logic [11:0] OFS_TOS_BASE = 12'h010;
  localparam logic [11:0] OFS_STATUS   = 12'h020;
  localparam logic [11:0] OFS_COUNT    = 12'h024;

  // Control register fields
  localparam int unsigned CTRL_STRICT_BIT = 0;
  localparam int unsigned CTRL_SEL_LSB    = 4;

  // Reset values
  localparam logic [31:0] RST_CTRL     = 32'h0000_0000;
  localparam logic [19:0] RST_PORT_LVL = 20'h0_0000;
  localparam logic [15:0] RST_COS_MAP  = 16'h0000;

  typedef struct packed {
    logic [3:0] port;
    logic       is_ip;
    logic       has_cos;
    logic [2:0] cos;
    logic [5:0] tos;
  } qpc_frame_t;

  typedef struct packed {
    logic       strict;
    logic [2:0] sel;
  } qpc_cfg_t;

endpackage

// ==== qpc_queue_model.sv ====
// Egress queue model: per-queue frame counts drained by the scheduler grants
`timescale 1ns/1ps
`default_nettype none
module qpc_queue_model
  import qpc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        load,
  input  wire logic [15:0] load_cnt,
  input  wire logic        stall,
  input  wire logic        grant_valid,
  input  wire logic [1:0]  grant_q,
  output logic [3:0]       q_nonempty,
  output logic             grant_ready
);
  logic [3:0] cnt_q [4];

  // Stall holds ready low so the scheduler must keep its choice
  assign grant_ready = !stall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) cnt_q[i] <= 4'h0;
    end else if (load) begin
      for (int i = 0; i < 4; i++) cnt_q[i] <= load_cnt[4*i +: 4];
    end else if (grant_valid && grant_ready && cnt_q[grant_q] != 4'h0) begin
      // A grant on an empty queue is ignored, as a real queue has nothing to pop
      cnt_q[grant_q] <= cnt_q[grant_q] - 4'h1;
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) q_nonempty[i] = (cnt_q[i] != 4'h0);
  end
endmodule
`default_nettype wire

// ==== qpc_sched.sv ====
// Egress scheduler over the four priority queues, weighted or strict
`timescale 1ns/1ps
`default_nettype none
module qpc_sched
  import qpc_pkg::*;
#(
  parameter int unsigned NQ = NUM_QUEUES
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          ce,
  input  wire logic          strict,
  input  wire logic [NQ-1:0] q_nonempty,
  input  wire logic          grant_ready,
  output logic               grant_valid,
  output logic [1:0]         grant_q
);

  if (NQ != 4) begin : g_bad_nq
    $error("qpc_sched supports exactly four queues");
  end

  logic [3:0] credit_q [NQ];
  logic [3:0] wgt [NQ];
  logic [1:0] strict_pick;
  logic [1:0] wrr_pick;
  logic       wrr_found;
  logic       take;

  assign wgt[0] = WGT_Q0;
  assign wgt[1] = WGT_Q1;
  assign wgt[2] = WGT_Q2;
  assign wgt[3] = WGT_Q3;

  always_comb begin
    strict_pick = 2'h0;
    for (int i = 0; i < NQ; i++) begin
      if (q_nonempty[i]) strict_pick = 2'(i);
    end
  end

  // Highest non-empty queue that still holds credit in this round
  always_comb begin
    wrr_pick  = 2'h0;
    wrr_found = 1'b0;
    for (int i = 0; i < NQ; i++) begin
      if (q_nonempty[i] && credit_q[i] != 4'h0) begin
        wrr_pick  = 2'(i);
        wrr_found = 1'b1;
      end
    end
  end

  assign grant_valid = |q_nonempty;
  assign grant_q     = (strict || !wrr_found) ? strict_pick : wrr_pick;
  assign take        = ce && grant_valid && grant_ready;

  // New round reloads every credit, so queues share in 8:4:2:1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      credit_q[0] <= WGT_Q0;
      credit_q[1] <= WGT_Q1;
      credit_q[2] <= WGT_Q2;
      credit_q[3] <= WGT_Q3;
    end else if (take && !strict) begin
      for (int i = 0; i < NQ; i++) begin
        if (!wrr_found) credit_q[i] <= wgt[i] - ((2'(i) == grant_q) ? 4'h1 : 4'h0);
        else if (2'(i) == grant_q) credit_q[i] <= credit_q[i] - 4'h1;
      end
    end
  end

  AST_STRICT_HIGHEST: assert property (@(posedge pclk) disable iff (!presetn)
    (strict && grant_valid) |-> !(|(q_nonempty >> (grant_q + 3'h1))))
    else $error("strict grant skipped a higher non-empty queue");

  AST_WRR_CREDIT: assert property (@(posedge pclk) disable iff (!presetn)
    (!strict && wrr_found) |-> credit_q[grant_q] != 4'h0 && credit_q[grant_q] <= wgt[grant_q])
    else $error("weighted grant to a queue without credit");

endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the QoS priority classifier
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import qpc_pkg::*;
  typedef struct packed {
    logic [2:0] sel;
    qpc_frame_t f;
    logic [1:0] q;
  } qpc_row_t;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        in_valid, out_valid, grant_ready, grant_valid, load, stall, err;
  qpc_frame_t  in_frame;
  logic [3:0]  out_port, q_nonempty;
  logic [1:0]  out_queue, grant_q;
  logic [15:0] load_cnt;
  int          n_fail, num_checks;
  logic [3:0]  wgt [4] = '{WGT_Q0, WGT_Q1, WGT_Q2, WGT_Q3};
  logic [1:0]  strict_seq [6] = '{2'h3, 2'h3, 2'h1, 2'h1, 2'h1, 2'h0};
  qpc_row_t rows [14] = '{
    '{SEL_DISABLE, '{4'h3, 1'b1, 1'b1, 3'h0, 6'h19}, LVL_LOWEST},
    '{SEL_PORT, '{4'h3, 1'b1, 1'b1, 3'h0, 6'h19}, LVL_HIGH},
    '{SEL_PORT, '{4'h9, 1'b0, 1'b0, 3'h0, 6'h00}, LVL_LOW},
    '{SEL_COS_ONLY, '{4'h0, 1'b0, 1'b1, 3'h0, 6'h00}, LVL_HIGH},
    '{SEL_COS_ONLY, '{4'h3, 1'b1, 1'b0, 3'h0, 6'h19}, LVL_LOWEST},
    '{SEL_TOS_ONLY, '{4'h1, 1'b1, 1'b1, 3'h0, 6'h19}, LVL_HIGH},
    '{SEL_TOS_ONLY, '{4'h1, 1'b1, 1'b0, 3'h0, 6'h10}, LVL_MIDDLE},
    '{SEL_TOS_ONLY, '{4'h3, 1'b1, 1'b0, 3'h0, 6'h3f}, LVL_LOWEST},
    '{SEL_COS_FIRST, '{4'h2, 1'b1, 1'b1, 3'h1, 6'h19}, LVL_MIDDLE},
    '{SEL_COS_FIRST, '{4'h2, 1'b1, 1'b0, 3'h0, 6'h19}, LVL_HIGH},
    '{SEL_COS_FIRST, '{4'h2, 1'b0, 1'b0, 3'h0, 6'h19}, LVL_MIDDLE},
    '{SEL_TOS_FIRST, '{4'h0, 1'b1, 1'b1, 3'h0, 6'h10}, LVL_MIDDLE},
    '{SEL_TOS_FIRST, '{4'h8, 1'b0, 1'b1, 3'h2, 6'h19}, LVL_LOW},
    '{SEL_TOS_FIRST, '{4'h1, 1'b0, 1'b0, 3'h0, 6'h19}, LVL_LOW}};

  qpc_classifier DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .in_valid(in_valid), .in_frame(in_frame),
    .out_valid(out_valid), .out_port(out_port), .out_queue(out_queue),
    .q_nonempty(q_nonempty), .grant_ready(grant_ready), .grant_valid(grant_valid),
    .grant_q(grant_q));
  qpc_queue_model QM (.pclk(pclk), .presetn(presetn), .load(load), .load_cnt(load_cnt),
    .stall(stall), .grant_valid(grant_valid), .grant_q(grant_q), .q_nonempty(q_nonempty),
    .grant_ready(grant_ready));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    forever begin
      @(posedge pclk);
      if (pready === 1'b1) break;
      if (++n > 50) begin
        n_fail++;
        end_of_test();
      end
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic send(input qpc_frame_t f);
    @(posedge pclk);
    in_valid <= 1'b1;
    in_frame <= f;
    @(posedge pclk);
    in_valid <= 1'b0;
    #1;
  endtask

  task automatic fill(input logic [15:0] c);
    @(posedge pclk);
    load <= 1'b1;
    load_cnt <= c;
    @(posedge pclk);
    load <= 1'b0;
  endtask

  initial begin
    {psel, penable, pwrite, in_valid, load, stall} = '0;
    paddr = '0;
    pwdata = '0;
    in_frame = '0;
    load_cnt = '0;
    ce = 1'b1;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      if (a == 3) continue;
      apb(1'b0, 12'(4 * a), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 12'h030, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, OFS_PORT_LVL, 32'h0004_e4e4);
    apb(1'b0, OFS_PORT_LVL, 32'h0);
    chk(rd, 32'h0004_e4e4);
    apb(1'b1, OFS_COS_MAP, 32'h0000_1b1b);
    apb(1'b1, OFS_TOS_BASE + 12'h004, 32'h000c_0002);
    foreach (rows[i]) begin
      apb(1'b1, OFS_CTRL, 32'(rows[i].sel) << CTRL_SEL_LSB);
      send(rows[i].f);
      chk({out_valid, out_port, out_queue}, {1'b1, rows[i].f.port, rows[i].q});
    end
    apb(1'b0, OFS_COUNT, 32'h0);
    chk(rd, 32'd14);
    // Port numbers past the last port must not produce a result
    send('{4'ha, 1'b0, 1'b0, 3'h0, 6'h00});
    chk(out_valid, 32'h0);
    apb(1'b1, OFS_TOS_BASE + 12'h00c, 32'hc000_0000);
    apb(1'b0, OFS_TOS_BASE + 12'h00c, 32'h0);
    chk(rd, 32'hc000_0000);
    // Unused selection codes must read back as disable
    apb(1'b1, OFS_CTRL, (32'h7 << CTRL_SEL_LSB) | (32'h1 << CTRL_STRICT_BIT));
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h1 << CTRL_STRICT_BIT);
    apb(1'b1, OFS_CTRL, 32'h0);
    fill(16'hffff);
    for (int q = 3; q >= 0; q--) begin
      repeat (wgt[q]) begin
        #1 chk(grant_q, q);
        @(posedge pclk);
      end
    end
    stall <= 1'b1;
    repeat (3) @(posedge pclk);
    #1 chk({grant_valid, grant_q}, 3'h7);
    @(posedge pclk);
    stall <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h1);
    fill(16'h2031);
    foreach (strict_seq[i]) begin
      #1 chk(grant_q, strict_seq[i]);
      @(posedge pclk);
    end
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, {26'h0, 1'b0, 2'h0, 1'b0, LVL_LOW});
    // Clock enable low: writes and frames are ignored
    ce <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h0);
    send('{4'h0, 1'b1, 1'b1, 3'h0, 6'h00});
    chk(out_valid, 32'h0);
    @(posedge pclk);
    ce <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h1 << CTRL_STRICT_BIT);
    apb(1'b0, OFS_COUNT, 32'h0);
    chk(rd, 32'd14);
    // Reset in mid-run clears the tables and the count
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_TOS_BASE + 12'h004, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, OFS_COUNT, 32'h0);
    chk(rd, 32'h0);
    end_of_test();
  end

  initial begin
    #1ms;
    n_fail++;
    end_of_test();
  end
endmodule
`default_nettype wire
